// >>> core/msi_cfg.svh
// constants of the monitor sequencer and interrupt block
`ifndef MSI_CFG_SVH
`define MSI_CFG_SVH
// register offsets
`define MSI_A_RUN 8'h40
`define MSI_A_ST1 8'h41
`define MSI_A_ST2 8'h42
`define MSI_A_SF 8'h7c
`define MSI_A_VEN 8'h7e
`define MSI_A_SETUP 8'h7f
`define MSI_A_FEN 8'h80
`define MSI_A_TEN 8'h82
`define MSI_A_RD1 8'h25
`define MSI_A_AMB 8'h26
`define MSI_A_RD2 8'h27
`define MSI_A_VCC 8'h21
`define MSI_A_VCCP 8'h20
// reset values
`define MSI_SF_RST 8'h40
`define MSI_ZERO 8'h00
// field positions
`define MSI_RUN_START 0
`define MSI_SF_CYCLE 1
`define MSI_SF_GIE 2
`define MSI_SETUP_T3 0
`define MSI_SETUP_P2 1
`define MSI_SETUP_SRST 7
`define MSI_GRP 0
// channel order
`define MSI_CH_D1 3'h0
`define MSI_CH_AMB 3'h1
`define MSI_CH_VCC 3'h2
`define MSI_CH_VCCP 3'h3
`define MSI_CH_D2 3'h4
// status bit masks
`define MSI_S1_VOLT 8'h03
`define MSI_S1_TEMP 8'h70
`define MSI_S2_FAN 8'h0f
// substitution codes
`define MSI_FAULT_CODE 8'h80
`define MSI_OFF_CODE 8'h00
// timing
`define MSI_CLK_KHZ 10000
`define MSI_IDLE_MS 1000
`define MSI_IDLE_CYC (`MSI_IDLE_MS * `MSI_CLK_KHZ)
`endif

// >>> core/msi_pkg.sv
// types of the monitor sequencer and interrupt block
package msi_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_PAUSE} msi_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } msi_bus_t;
  typedef struct packed {
    logic done;
    logic [7:0] data;
    logic fault;
    logic neg_gnd;
  } msi_conv_t;
  typedef logic [4:0][7:0] msi_lim_t;
endpackage

// >>> core/msi_monitor.sv
// hardware monitor sequencer, limit status and interrupt output
`timescale 1ns/1ns
`include "msi_cfg.svh"
module msi_monitor #(
  parameter int IDLE_CYC = `MSI_IDLE_CYC
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire msi_pkg::msi_bus_t BUS_I,
  output logic [7:0] RDATA_O,
  input wire logic ARA_I,
  output logic ARA_ACK_O,
  output logic CONV_REQ_O,
  output logic [2:0] CONV_CH_O,
  input wire msi_pkg::msi_conv_t CONV_I,
  input wire msi_pkg::msi_lim_t LIM_LO_I,
  input wire msi_pkg::msi_lim_t LIM_HI_I,
  input wire logic [3:0] FAN_ERR_I,
  input wire logic FAN_PWM_TWO_I,
  output logic [2:0] FAN_FULL_O,
  output logic IRQ_N_O,
  output logic FAN_DRIVE_TWO_PIN_O,
  output logic FAN_DRIVE_TWO_PIN_OE_O,
  output logic TACH_THREE_PIN_O,
  output logic TACH_THREE_PIN_OE_O
);
  msi_pkg::msi_state_t state_r, state_nxt;
  logic [2:0] ch_r, ch_nxt;
  logic [23:0] idle_cnt_r;
  logic [7:0] run_r, sf_r, ven_r, setup_r, fen_r, ten_r;
  logic [7:0] st1_r, st1_nxt, st2_r, st2_nxt;
  logic [4:0][7:0] rdg_r;
  logic [4:0] cond_r;
  logic [1:0] fcond_r;
  logic [2:0] fan_full_r;
  logic srst_r, ack_r, irq_act;
  logic [7:0] rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr = BUS_I.wr;
  wire rd = BUS_I.rd;
  wire [7:0] a = BUS_I.addr;
  wire w_run = wr && (a == `MSI_A_RUN);
  wire w_sf = wr && (a == `MSI_A_SF);
  wire w_ven = wr && (a == `MSI_A_VEN);
  wire w_setup = wr && (a == `MSI_A_SETUP);
  wire w_fen = wr && (a == `MSI_A_FEN);
  wire w_ten = wr && (a == `MSI_A_TEN);
  wire r_st1 = rd && (a == `MSI_A_ST1);
  wire r_st2 = rd && (a == `MSI_A_ST2);
  wire running = run_r[`MSI_RUN_START];
  wire cyc_mode = sf_r[`MSI_SF_CYCLE];
  wire gie = sf_r[`MSI_SF_GIE];
  wire den1 = ten_r[1];
  wire den2 = ten_r[3];
  logic [7:0] rmux;
  always_comb begin
    rmux = `MSI_ZERO;
    if (a == `MSI_A_RUN) begin
      rmux = run_r;
    end else if (a == `MSI_A_ST1) begin
      rmux = st1_r;
    end else if (a == `MSI_A_ST2) begin
      rmux = st2_r;
    end else if (a == `MSI_A_SF) begin
      rmux = sf_r;
    end else if (a == `MSI_A_VEN) begin
      rmux = ven_r;
    end else if (a == `MSI_A_SETUP) begin
      rmux = setup_r;
    end else if (a == `MSI_A_FEN) begin
      rmux = fen_r;
    end else if (a == `MSI_A_TEN) begin
      rmux = ten_r;
    end else if (a == `MSI_A_RD1) begin
      rmux = rdg_r[`MSI_CH_D1];
    end else if (a == `MSI_A_AMB) begin
      rmux = rdg_r[`MSI_CH_AMB];
    end else if (a == `MSI_A_VCC) begin
      rmux = rdg_r[`MSI_CH_VCC];
    end else if (a == `MSI_A_VCCP) begin
      rmux = rdg_r[`MSI_CH_VCCP];
    end else if (a == `MSI_A_RD2) begin
      rmux = rdg_r[`MSI_CH_D2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  wire done = CONV_I.done && (state_r == msi_pkg::ST_WAIT);
  wire last = (ch_r == `MSI_CH_D2);
  wire idle_end = (idle_cnt_r == 24'(IDLE_CYC - 1));
  always_comb begin
    state_nxt = state_r;
    ch_nxt = ch_r;
    case (state_r)
      msi_pkg::ST_IDLE: begin
        ch_nxt = `MSI_CH_D1;
        if (running) begin
          state_nxt = msi_pkg::ST_REQ;
        end
      end
      msi_pkg::ST_REQ: begin
        state_nxt = msi_pkg::ST_WAIT;
      end
      msi_pkg::ST_WAIT: begin
        if (done) begin
          ch_nxt = last ? `MSI_CH_D1 : ch_r + 3'h1;
          state_nxt = (last && cyc_mode) ? msi_pkg::ST_PAUSE : msi_pkg::ST_REQ;
        end
      end
      msi_pkg::ST_PAUSE: begin
        if (idle_end) begin
          state_nxt = msi_pkg::ST_REQ;
        end
      end
      default: state_nxt = msi_pkg::ST_IDLE;
    endcase
    // a stopped monitor abandons any conversion in flight
    if (!running) begin
      state_nxt = msi_pkg::ST_IDLE;
    end
  end
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_r <= msi_pkg::ST_IDLE;
      ch_r <= `MSI_CH_D1;
      idle_cnt_r <= 24'h000000;
    end else begin
      state_r <= state_nxt;
      ch_r <= ch_nxt;
      idle_cnt_r <= (state_r == msi_pkg::ST_PAUSE) ? idle_cnt_r + 24'h000001 : 24'h000000;
    end
  end
  assign CONV_REQ_O = (state_r == msi_pkg::ST_REQ) || (state_r == msi_pkg::ST_WAIT);
  assign CONV_CH_O = ch_r;

  ////////////////////////////////////////////////////////////////////////////////
  // result substitution and limit compare
  wire is_d1 = (ch_r == `MSI_CH_D1);
  wire is_d2 = (ch_r == `MSI_CH_D2);
  wire is_diode = is_d1 || is_d2;
  wire is_temp = is_diode || (ch_r == `MSI_CH_AMB);
  wire den = is_d1 ? den1 : den2;
  wire flt = is_diode && CONV_I.fault;
  wire [7:0] val = !flt ? CONV_I.data :
                   !den ? `MSI_OFF_CODE :
                   CONV_I.neg_gnd ? CONV_I.data : `MSI_FAULT_CODE;
  wire [7:0] lo = LIM_LO_I[ch_r];
  wire [7:0] hi = LIM_HI_I[ch_r];
  // temperatures are two's complement, voltages unsigned
  wire lt = is_temp ? ($signed(val) < $signed(lo)) : (val < lo);
  wire gt = is_temp ? ($signed(val) > $signed(hi)) : (val > hi);
  wire eq = (val == lo) || (val == hi);
  wire err = lt || gt || (cyc_mode && eq) || (is_diode && (val == `MSI_FAULT_CODE));
  logic [4:0] chsel;
  logic [4:0] ev_ch;
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_ch
      assign chsel[g] = (ch_r == 3'(g));
      assign ev_ch[g] = done && chsel[g] && err;
      always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
          rdg_r[g] <= `MSI_ZERO;
          cond_r[g] <= 1'b0;
        end else if (done && chsel[g]) begin
          rdg_r[g] <= val;
          cond_r[g] <= err;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      run_r <= `MSI_ZERO;
      sf_r <= `MSI_SF_RST;
      ven_r <= `MSI_ZERO;
      setup_r <= `MSI_ZERO;
      fen_r <= `MSI_ZERO;
      ten_r <= `MSI_ZERO;
      srst_r <= 1'b0;
    end else if (srst_r) begin
      // soft initialisation spares the readings, the limit conditions and the zone full drive
      run_r <= `MSI_ZERO;
      sf_r <= `MSI_SF_RST;
      ven_r <= `MSI_ZERO;
      setup_r <= `MSI_ZERO;
      fen_r <= `MSI_ZERO;
      ten_r <= `MSI_ZERO;
      srst_r <= 1'b0;
    end else begin
      if (w_run) begin
        run_r <= BUS_I.wdata;
      end
      if (ack_r) begin
        // alert answer drops global enable, winning over a write
        sf_r <= sf_r & ~(8'h01 << `MSI_SF_GIE);
      end else if (w_sf) begin
        sf_r <= BUS_I.wdata;
      end
      if (w_ven) begin
        ven_r <= BUS_I.wdata;
      end
      if (w_setup) begin
        setup_r <= BUS_I.wdata & ~(8'h01 << `MSI_SETUP_SRST);
      end
      if (w_fen) begin
        fen_r <= BUS_I.wdata;
      end
      if (w_ten) begin
        ten_r <= BUS_I.wdata;
      end
      srst_r <= w_setup && BUS_I.wdata[`MSI_SETUP_SRST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky status
  wire [7:0] ev1 = {1'b0, ev_ch[`MSI_CH_D2], ev_ch[`MSI_CH_AMB], ev_ch[`MSI_CH_D1],
                    2'b00, ev_ch[`MSI_CH_VCCP], ev_ch[`MSI_CH_VCC]};
  wire [7:0] cnd1 = {1'b0, cond_r[`MSI_CH_D2], cond_r[`MSI_CH_AMB], cond_r[`MSI_CH_D1],
                     2'b00, cond_r[`MSI_CH_VCCP], cond_r[`MSI_CH_VCC]};
  wire [7:0] en1 = {1'b0, ten_r[3], ten_r[2], ten_r[1], 2'b00, ven_r[2], ven_r[1]};
  wire fev1 = done && is_d1 && CONV_I.fault;
  wire fev2 = done && is_d2 && CONV_I.fault;
  wire [7:0] ev2 = {fev2, fev1, 2'b00, FAN_ERR_I};
  wire [7:0] cnd2 = {fcond_r[1], fcond_r[0], 2'b00, FAN_ERR_I};
  // fault bits follow the diode enable, so a disabled diode never flags
  wire [7:0] en2 = {den2, den1, 2'b00, fen_r[4:1]};
  always_comb begin
    // clear on read only when cause gone; set wins
    st1_nxt = (r_st1 ? (st1_r & cnd1) : st1_r) | (ev1 & en1);
    st2_nxt = (r_st2 ? (st2_r & cnd2) : st2_r) | (ev2 & en2);
  end
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st1_r <= `MSI_ZERO;
      st2_r <= `MSI_ZERO;
      fcond_r <= 2'b00;
    end else if (srst_r) begin
      // zero after initialisation; bus writes never reach here
      st1_r <= `MSI_ZERO;
      st2_r <= `MSI_ZERO;
      fcond_r <= 2'b00;
    end else begin
      st1_r <= st1_nxt;
      st2_r <= st2_nxt;
      if (done && is_d1) begin
        fcond_r[0] <= CONV_I.fault;
      end
      if (done && is_d2) begin
        fcond_r[1] <= CONV_I.fault;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // zone full drive, read data, alert answer
  wire load80_1 = done && is_d1 && (val == `MSI_FAULT_CODE);
  wire load80_2 = done && is_d2 && (val == `MSI_FAULT_CODE);
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fan_full_r <= 3'b000;
      rdata_r <= `MSI_ZERO;
      ack_r <= 1'b0;
    end else begin
      // zone one and three forced full
      if (done && is_d1) begin
        fan_full_r[0] <= load80_1;
      end
      if (done && is_d2) begin
        fan_full_r[2] <= load80_2;
      end
      if (rd) begin
        rdata_r <= rmux;
      end
      // answer only while pulling the alert
      ack_r <= ARA_I && irq_act;
    end
  end
  assign FAN_FULL_O = fan_full_r;
  assign RDATA_O = rdata_r;
  assign ARA_ACK_O = ack_r;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt output
  // group gates
  wire t_req = |(st1_r & `MSI_S1_TEMP) && ten_r[`MSI_GRP];
  wire v_req = |(st1_r & `MSI_S1_VOLT) && ven_r[`MSI_GRP];
  wire f_req = |(st2_r & `MSI_S2_FAN) && fen_r[`MSI_GRP];
  // level while any enabled limit or fan bit stands
  assign irq_act = running && gie && (t_req || v_req || f_req);
  assign IRQ_N_O = !irq_act;
  // pin routing; both pins are open drain when carrying the alert
  wire sel_p2 = setup_r[`MSI_SETUP_P2];
  wire sel_t3 = setup_r[`MSI_SETUP_T3];
  assign FAN_DRIVE_TWO_PIN_O = sel_p2 ? 1'b0 : FAN_PWM_TWO_I;
  assign FAN_DRIVE_TWO_PIN_OE_O = sel_p2 ? irq_act : 1'b1;
  assign TACH_THREE_PIN_O = 1'b0;
  assign TACH_THREE_PIN_OE_O = sel_t3 && irq_act;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  property p_stop_quiet;
    @(posedge CLK_I) disable iff (SYS_RST_I) !running |=> !CONV_REQ_O;
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("conversion while stopped");
  property p_order;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      done && running && !last |=> CONV_CH_O == $past(ch_r) + 3'h1;
  endproperty
  a_order: assert property (p_order) else $error("channel order broken");
  property p_cont;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      done && last && !cyc_mode && running |=> CONV_REQ_O && CONV_CH_O == `MSI_CH_D1;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode paused");
  property p_pause;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      done && last && cyc_mode && running |=> !CONV_REQ_O [*8];
  endproperty
  a_pause: assert property (p_pause) else $error("cycle mode did not idle");
  property p_subst;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      done && is_d1 && CONV_I.fault && den1 && !CONV_I.neg_gnd && !srst_r
      |=> rdg_r[0] == `MSI_FAULT_CODE && st1_r[4];
  endproperty
  a_subst: assert property (p_subst) else $error("fault code not loaded");
  property p_off;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      done && is_d2 && CONV_I.fault && !den2 && !st2_r[7] && !srst_r
      |=> rdg_r[4] == `MSI_OFF_CODE && !st2_r[7];
  endproperty
  a_off: assert property (p_off) else $error("disabled diode misbehaved");
  property p_sticky;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      !r_st1 && !srst_r |=> (st1_r & $past(st1_r)) == $past(st1_r);
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");
  property p_gie;
    @(posedge CLK_I) disable iff (SYS_RST_I) !IRQ_N_O |-> gie && running;
  endproperty
  a_gie: assert property (p_gie) else $error("interrupt without enables");
  property p_ara;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      ARA_I && irq_act && !srst_r |=> ARA_ACK_O ##1 IRQ_N_O && !gie;
  endproperty
  a_ara: assert property (p_ara) else $error("alert call not answered");
  property p_full;
    @(posedge CLK_I) disable iff (SYS_RST_I) load80_2 |=> FAN_FULL_O[2];
  endproperty
  a_full: assert property (p_full) else $error("zone not forced full");
  property p_tach;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      sel_t3 && !IRQ_N_O |-> TACH_THREE_PIN_OE_O && !TACH_THREE_PIN_O;
  endproperty
  a_tach: assert property (p_tach) else $error("tach pin not pulled");
  c_pass: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) done && last);
  c_irq: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) $fell(IRQ_N_O));
  c_ack: cover property (@(posedge CLK_I) disable iff (SYS_RST_I) ARA_ACK_O);
  c_pause: cover property (@(posedge CLK_I) disable iff (SYS_RST_I)
                           state_r == msi_pkg::ST_PAUSE && idle_end);
endmodule

// >>> tb/msi_conv_model.sv
// converter model that answers conversion requests after a fixed latency
`timescale 1ns/1ns
module msi_conv_model #(
  parameter int LAT = 4
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic req_i,
  input wire logic [2:0] ch_i,
  input wire msi_pkg::msi_lim_t val_i,
  input wire logic [4:0] flt_i,
  input wire logic [4:0] ng_i,
  output msi_pkg::msi_conv_t conv_o
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // between results the data lines change every cycle, so a stale value never matches
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cnt <= 0;
      conv_o <= '0;
    end else if (req_i && cnt == LAT) begin
      cnt <= 0;
      conv_o <= {1'b1, val_i[ch_i], flt_i[ch_i], ng_i[ch_i]};
    end else begin
      cnt <= req_i ? cnt + 1 : 0;
      conv_o <= {1'b0, ~conv_o.data, 2'b00};
    end
  end
endmodule

// >>> tb/tb_top.sv
// register level testbench of the monitor sequencer with a converter model
`timescale 1ns/1ns
`include "msi_cfg.svh"
module tb_top;
  localparam int IDLE = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ara = 1'b0;
  logic ack, req, irq_n, p2, p2oe, t3, t3oe;
  logic [7:0] rdata;
  logic [2:0] ch, full;
  logic [2:0] exp_ch = 3'h0;
  logic ord_en = 1'b0;
  logic cont = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [4:0] ng = 5'h00;
  logic [3:0] fan_err = 4'h0;
  msi_pkg::msi_bus_t bus = '0;
  msi_pkg::msi_conv_t conv;
  msi_pkg::msi_lim_t val = {5{8'h30}};
  msi_pkg::msi_lim_t lo = {5{8'h01}};
  msi_pkg::msi_lim_t hi = {5{8'h60}};
  int bad_count = 0;
  int n_compared = 0;
  int n_done = 0;
  int k;
  always #50 clk = ~clk;
  msi_monitor #(.IDLE_CYC(IDLE)) dut_u (.CLK_I(clk), .SYS_RST_I(rst), .BUS_I(bus),
    .RDATA_O(rdata), .ARA_I(ara), .ARA_ACK_O(ack), .CONV_REQ_O(req), .CONV_CH_O(ch),
    .CONV_I(conv), .LIM_LO_I(lo), .LIM_HI_I(hi), .FAN_ERR_I(fan_err), .FAN_PWM_TWO_I(1'b1),
    .FAN_FULL_O(full), .IRQ_N_O(irq_n), .FAN_DRIVE_TWO_PIN_O(p2),
    .FAN_DRIVE_TWO_PIN_OE_O(p2oe), .TACH_THREE_PIN_O(t3), .TACH_THREE_PIN_OE_O(t3oe));
  msi_conv_model model_u (.CLK_I(clk), .SYS_RST_I(rst), .req_i(req), .ch_i(ch),
    .val_i(val), .flt_i(flt), .ng_i(ng), .conv_o(conv));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", bad_count, n_compared);
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    bus = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    bus = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    bus = '0;
    chk(rdata, e, "read");
  endtask
  task automatic stuck(input string m);
    bad_count++;
    $display("mismatch at %0t: timeout %s", $time, m);
    stop_test();
  endtask
  // waits for n more conversions, bounded
  task automatic conv_n(input int n);
    int t0;
    t0 = n_done;
    for (int i = 0; i < 400 && n_done < t0 + n; i++) @(negedge clk);
    if (n_done < t0 + n) stuck("conversion");
  endtask
  task automatic wait_low;
    for (int i = 0; i < 200 && req; i++) @(negedge clk);
    if (req) stuck("pause");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (conv.done && req) begin
      n_done <= n_done + 1;
      exp_ch <= (ch == 3'h4) ? 3'h0 : ch + 3'h1;
      if (ord_en && ch !== exp_ch) chk({5'h0, ch}, {5'h0, exp_ch}, "channel order");
    end
    if (ord_en && cont && !req) chk(8'h00, 8'h01, "pause in continuous mode");
  end
  initial begin
    #10000000;
    stuck("run");
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk({7'h00, irq_n}, 8'h01, "idle irq");
    rd(`MSI_A_RUN, 8'h00);
    rd(`MSI_A_SF, `MSI_SF_RST);
    rd(`MSI_A_ST1, 8'h00);
    rd(`MSI_A_ST2, 8'h00);
    wr(`MSI_A_ST1, 8'hff);
    rd(`MSI_A_ST1, 8'h00);
    rd(8'h3f, 8'h00);
    wr(`MSI_A_VEN, 8'h07);
    wr(`MSI_A_TEN, 8'h0f);
    wr(`MSI_A_SETUP, 8'h01);
    wr(`MSI_A_SF, 8'h44);
    chk({7'h00, irq_n}, 8'h01, "irq before start");
    wr(`MSI_A_RUN, 8'h01);
    repeat (3) @(negedge clk);
    ord_en = 1'b1;
    cont = 1'b1;
    conv_n(10);
    rd(`MSI_A_ST1, 8'h00);
    chk({6'h00, p2, p2oe}, 8'h03, "pwm pin");
    // out of limit supply sets status and drives the interrupt
    val[2] = 8'h70;
    conv_n(6);
    chk({7'h00, irq_n}, 8'h00, "irq low");
    chk({6'h00, t3, t3oe}, 8'h01, "tach three pin");
    rd(`MSI_A_VCC, 8'h70);
    rd(`MSI_A_ST1, 8'h01);
    rd(`MSI_A_ST1, 8'h01);
    val[2] = 8'h30;
    conv_n(6);
    chk({7'h00, irq_n}, 8'h00, "irq held");
    rd(`MSI_A_ST1, 8'h01);
    rd(`MSI_A_ST1, 8'h00);
    chk({7'h00, irq_n}, 8'h01, "irq released");
    wr(`MSI_A_VEN, 8'h05);
    val[2] = 8'h70;
    conv_n(6);
    rd(`MSI_A_ST1, 8'h00);
    wr(`MSI_A_VEN, 8'h06);
    conv_n(6);
    chk({7'h00, irq_n}, 8'h01, "group off");
    wr(`MSI_A_VEN, 8'h07);
    chk({7'h00, irq_n}, 8'h00, "group on");
    // host clears the global enable around status service
    wr(`MSI_A_SF, 8'h40);
    chk({7'h00, irq_n}, 8'h01, "global off");
    wr(`MSI_A_SF, 8'h44);
    chk({7'h00, irq_n}, 8'h00, "global on");
    @(negedge clk);
    ara = 1'b1;
    @(negedge clk);
    ara = 1'b0;
    chk({7'h00, ack}, 8'h01, "alert answer");
    @(negedge clk);
    chk({7'h00, irq_n}, 8'h01, "alert release");
    rd(`MSI_A_SF, 8'h40);
    val[2] = 8'h30;
    conv_n(6);
    rd(`MSI_A_ST1, 8'h01);
    rd(`MSI_A_ST1, 8'h00);
    wr(`MSI_A_SF, 8'h44);
    // a disabled diode reads zero on a fault and flags nothing
    wr(`MSI_A_TEN, 8'h0d);
    flt[0] = 1'b1;
    conv_n(6);
    rd(`MSI_A_RD1, `MSI_OFF_CODE);
    rd(`MSI_A_ST2, 8'h00);
    wr(`MSI_A_TEN, 8'h0f);
    conv_n(6);
    rd(`MSI_A_RD1, `MSI_FAULT_CODE);
    rd(`MSI_A_ST2, 8'h40);
    rd(`MSI_A_ST1, 8'h10);
    chk({5'h00, full}, 8'h01, "zone one full");
    chk({7'h00, irq_n}, 8'h00, "diode irq");
    flt[0] = 1'b0;
    conv_n(6);
    chk({5'h00, full}, 8'h00, "zone one normal");
    rd(`MSI_A_ST2, 8'h40);
    rd(`MSI_A_ST2, 8'h00);
    rd(`MSI_A_ST1, 8'h10);
    rd(`MSI_A_ST1, 8'h00);
    flt[4] = 1'b1;
    conv_n(6);
    chk({5'h00, full}, 8'h04, "zone three full");
    rd(`MSI_A_RD2, `MSI_FAULT_CODE);
    ng[4] = 1'b1;
    conv_n(6);
    rd(`MSI_A_RD2, 8'h30);
    rd(`MSI_A_ST2, 8'h80);
    chk({5'h00, full}, 8'h00, "no zone three");
    rd(`MSI_A_ST1, 8'h40);
    {flt[4], ng[4]} = 2'b00;
    conv_n(6);
    rd(`MSI_A_ST2, 8'h80);
    rd(`MSI_A_ST2, 8'h00);
    // a fan error routed to fan drive two pulls that pin low
    wr(`MSI_A_SETUP, 8'h02);
    wr(`MSI_A_FEN, 8'h03);
    fan_err = 4'h1;
    @(negedge clk);
    chk({7'h00, irq_n}, 8'h00, "fan irq");
    chk({5'h00, p2, p2oe, t3oe}, 8'h02, "fan drive two pin");
    fan_err = 4'h0;
    rd(`MSI_A_ST2, 8'h01);
    chk({5'h00, p2, p2oe, t3oe}, 8'h00, "fan drive two idle");
    // cycle mode: equality counts, one pass then a pause
    val[3] = 8'h60;
    cont = 1'b0;
    wr(`MSI_A_SF, 8'h42);
    wait_low();
    k = 0;
    for (int i = 0; i < 100 && !req; i++) begin
      @(negedge clk);
      k++;
    end
    chk((k >= IDLE - 1 && k <= IDLE + 1) ? 8'h01 : 8'h00, 8'h01, "pause length");
    conv_n(3);
    wait_low();
    val[4] = 8'h50;
    rd(`MSI_A_RD2, 8'h30);
    conv_n(5);
    rd(`MSI_A_RD2, 8'h50);
    rd(`MSI_A_ST1, 8'h02);
    ord_en = 1'b0;
    wr(`MSI_A_SETUP, 8'h80);
    rd(`MSI_A_SF, `MSI_SF_RST);
    rd(`MSI_A_ST1, 8'h00);
    rd(`MSI_A_SETUP, 8'h00);
    stop_test();
  end
endmodule
